// File: bench/asc_core_model.sv
/*
  Behavioural analog core: a sample-and-hold feeding the converter code.
  Assumes the bench sets level and the block times the sample phases.
*/
`timescale 1ns/10ps
// ============================================================================
// core model
module asc_core_model (
  input  wire logic       pclk,      // bus clock
  input  wire logic       sampling,  // sample phase from the block
  input  wire logic [9:0] level,     // analog level from the bench
  output logic      [9:0] conv_code  // held code
);
  // the level is only taken while sampling, so late changes are lost
  always_ff @(posedge pclk) if (sampling) conv_code <= level;
endmodule

// File: bench/asc_ctrl_assertions.sv
/*
  Port checker for asc_ctrl: apb handshake, start, hold and pad outputs.
  Assumes it is bound to every asc_ctrl instance and sees its ports only.
*/
`timescale 1ns/10ps
// ============================================================================
// checker
module asc_ctrl_checker (
  input wire logic        pclk,         // bus clock
  input wire logic        presetn,      // async reset, active low
  input wire logic        pclk_en,      // run enable
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb access phase
  input wire logic [31:0] prdata,       // apb read data
  input wire logic        pready,       // apb ready
  input wire logic        pslverr,      // apb error
  input wire logic        seq_start,    // start pulse
  input wire logic        wait_mode,    // cpu wait
  input wire logic        freeze_mode,  // breakpoint
  input wire logic        trig_is_chan, // trigger on a channel
  input wire logic        trig_buf_en,  // channel buffer enable
  input wire logic        powered,      // analog power
  input wire logic        sampling,     // sample phase
  input wire logic [2:0]  conv_count    // next result slot
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb: exactly one wait state, ready for one cycle, error reads zero
  property p_pready_wait;
    psel && penable && !pready && pclk_en |=> pready;
  endproperty
  a_pready_wait: assert property (p_pready_wait) else $error("ready not in time");
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("ready held");
  property p_slverr_zero;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_slverr_zero: assert property (p_slverr_zero) else $error("error with data");
  // pads follow their causes
  property p_trig_buf;
    trig_buf_en |-> $past(trig_is_chan);
  endproperty
  a_trig_buf: assert property (p_trig_buf) else $error("buffer on");
  property p_powered;
    !powered |-> $past(wait_mode);
  endproperty
  a_powered: assert property (p_powered) else $error("off outside wait");
  // frozen clock enable holds the slot counter and the sample phase
  property p_hold_stable;
    !pclk_en |=> $stable(conv_count) && $stable(sampling);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("moved while held");
  // slot counter only steps by one or restarts at zero
  property p_count_step;
    $changed(conv_count) |-> conv_count == $past(conv_count) + 3'h1 || conv_count == 3'h0;
  endproperty
  a_count_step: assert property (p_count_step) else $error("slot jump");
  property p_start_samples;
    seq_start && pclk_en && powered && !wait_mode && !freeze_mode |=> sampling;
  endproperty
  a_start_samples: assert property (p_start_samples) else $error("no sample");
endmodule
bind asc_ctrl asc_ctrl_checker i_asc_ctrl_checker (.pclk(pclk), .presetn(presetn),
  .pclk_en(pclk_en), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .seq_start(seq_start), .wait_mode(wait_mode),
  .freeze_mode(freeze_mode), .trig_is_chan(trig_is_chan), .trig_buf_en(trig_buf_en),
  .powered(powered), .sampling(sampling), .conv_count(conv_count));

// File: bench/tb_asc_ctrl.sv
/*
  Self-checking bench for asc_ctrl over apb, with the core model attached.
  Assumes a 10 MHz pclk; prescaler kept at 2..9 so the conversion clock is legal.
*/
`timescale 1ns/10ps
// ============================================================================
// bench
module tb_asc_ctrl;
  logic        pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, err, irq, conv_clk, powered, trig_buf_en, sampling;
  logic        seq_start = 0, wait_mode = 0, freeze_mode = 0, trig_in = 0, trig_is_chan = 0;
  logic [9:0]  lvl = 0, conv_code;
  logic [2:0]  conv_count, c0;
  logic        ignore_next, scan_mode = 0;
  logic [3:0]  len;
  logic [1:0]  smp;
  int          seed = 32'hbd8d3e82, n_errors = 0, checks_done = 0, nr, nh, c, pv[3];

  asc_ctrl i_asc_ctrl (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .seq_start(seq_start), .scan_mode(scan_mode),
    .wait_mode(wait_mode), .freeze_mode(freeze_mode), .trig_in(trig_in),
    .trig_is_chan(trig_is_chan), .conv_code(conv_code), .irq(irq), .conv_clk(conv_clk),
    .powered(powered), .trig_buf_en(trig_buf_en), .sampling(sampling),
    .conv_count(conv_count), .ignore_next(ignore_next));
  asc_core_model i_asc_core_model (.pclk(pclk), .sampling(sampling), .level(lvl),
    .conv_code(conv_code));

  // clock and hang guard
  always #50 pclk = ~pclk;
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    final_report();
  end

  // ==========================================================================
  // tasks and expectations
  function automatic int exp_len(input logic [3:0] l);
    return (l == 4'h0 || l[3]) ? 8 : int'(l);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic pulse();
    seq_start <= 1'b1;
    @(posedge pclk) seq_start <= 1'b0;
  endtask
  // clear the old flag, start, then count samples until the interrupt
  task automatic seq();
    apb(1'b1, 8'h18, 32'h80);
    // start on a tick edge so the first sample phase is whole; prescaler is 2 here
    do @(posedge pclk); while (conv_clk !== 1'b0);
    do @(posedge pclk); while (conv_clk !== 1'b1);
    repeat (4) @(posedge pclk);
    pulse();
    nr = 0; nh = 0; c = 0;
    while (irq !== 1'b1) begin
      @(posedge pclk);
      nh += int'(sampling === 1'b1);
      nr += int'(sampling === 1'b1 && c == 0);
      c = int'(sampling === 1'b1);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("len_reset", 8'h0C, 32'h20);
    rd("prs_reset", 8'h10, 32'h05);
    apb(1'b1, 8'h08, 32'h7F);
    rd("pending_ro", 8'h08, 32'h7E);
    rd("unmapped", 8'h3C, 32'h0);
    chk("slverr", err, 1);
    $display("test registers done");
    // divider at legal prescales only
    pv = '{2, 5, 9};
    foreach (pv[k]) begin
      apb(1'b1, 8'h10, pv[k]);
      for (int r = 0; r < 2; r++) begin
        c = 0;
        do begin @(posedge pclk); c++; end while (conv_clk !== 1'b0);
        do begin @(posedge pclk); c++; end while (conv_clk !== 1'b1);
      end
      chk("div", c, 2 * (pv[k] + 1));
    end
    $display("test divider done");
    // random lengths and sample times, alternating resolutions, corners first
    for (int i = 0; i < 6; i++) begin
      len = (i == 0) ? 4'h0 : (i == 1) ? 4'h8 : 4'($random(seed));
      smp = 2'($random(seed));
      lvl <= 10'($random(seed));
      apb(1'b1, 8'h0C, {25'h0, len, 3'h0});
      apb(1'b1, 8'h10, {24'h0, i[0], smp, 5'h02});
      apb(1'b1, 8'h08, 32'h02);
      seq();
      chk("convs", nr, exp_len(len));
      chk("samp", nh, nr * (2 + (2 << smp)) * 6);
      rd("pending", 8'h08, 32'h03);
      rd("result", 8'(8'h40 + 8 * (nr - 1)), i[0] ? lvl[9:2] : lvl);
      apb(1'b1, 8'h08, 32'h0);
      @(posedge pclk);
      chk("irq_off", irq, 0);
    end
    $display("test sequences done");
    // flag clearing, normal then fast
    apb(1'b1, 8'h0C, 32'h08);
    apb(1'b1, 8'h10, 32'h02);
    apb(1'b1, 8'h08, 32'h02);
    seq();
    rd("res", 8'h40, lvl);
    apb(1'b0, 8'h2C, 32'h0);
    chk("ccf_kept", q[0], 1);
    rd("res", 8'h40, lvl);
    apb(1'b0, 8'h2C, 32'h0);
    chk("ccf_clr", q[0], 0);
    apb(1'b1, 8'h08, 32'h42);
    scan_mode <= 1'b1;
    seq();
    rd("res", 8'h40, lvl);
    apb(1'b0, 8'h2C, 32'h0);
    chk("ccf_fast", q[0], 0);
    // scan keeps sequencing, so the cleared flag comes back
    apb(1'b1, 8'h18, 32'h80);
    repeat (200) @(posedge pclk);
    chk("scan", irq, 1);
    scan_mode <= 1'b0;
    // fifo slots keep counting across sequences
    apb(1'b1, 8'h0C, 32'h0C);
    seq();
    c0 = conv_count;
    lvl <= 10'($random(seed));
    seq();
    chk("slot", conv_count, c0 + 3'h1);
    rd("fifo_res", 8'(8'h40 + 8 * c0), lvl);
    $display("test flags done");
    // each control write aborts a long sequence and starts none
    pv = '{8, 12, 16};
    foreach (pv[k]) begin
      apb(1'b1, 8'h0C, 32'h40);
      apb(1'b1, 8'h10, 32'h02);
      apb(1'b1, 8'h08, 32'h02);
      seq_start <= 1'b1;
      @(posedge pclk) seq_start <= 1'b0;
      pclk_en <= 1'b0;
      repeat (3) @(posedge pclk);
      pclk_en <= 1'b1;
      apb(1'b1, 8'(pv[k]), (k == 0) ? 32'h02 : (k == 1) ? 32'h40 : 32'h02);
      repeat (800) @(posedge pclk);
      chk("abort", irq, 0);
    end
    // trigger decode; results of the trigger channel are not checked
    trig_is_chan <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      trig_in <= ~k[0];
      apb(1'b1, 8'h08, {27'h0, k[1], k[0], 3'h4});
      repeat (3) @(posedge pclk);
      chk("buf", trig_buf_en, 1);
      chk("idle", sampling, 0);
      trig_in <= k[0];
      repeat (3) @(posedge pclk);
      chk("trig", sampling, 1);
      trig_in <= ~k[0];
      repeat (2) @(posedge pclk);
      trig_in <= k[0];
      repeat (2) @(posedge pclk);
      apb(1'b0, 8'h18, 32'h0);
      chk("overrun", q[5], !k[1]);
    end
    apb(1'b1, 8'h08, 32'h08);
    trig_in <= 1'b0;
    @(posedge pclk) trig_in <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("trig_off", sampling, 0);
    chk("buf_off", trig_buf_en, 0);
    $display("test triggers done");
    // wait power-down, then wake inside a sequence
    for (int a = 0; a < 2; a++) begin
      apb(1'b1, 8'h08, {26'h0, a[0], 5'h0});
      pulse();
      repeat (3) @(posedge pclk);
      wait_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("powered", powered, !a[0]);
      wait_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("ignore", ignore_next, a[0]);
    end
    // breakpoint responses: inside the first conversion, then after it
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, 8'h0C, 32'h40 | f);
      freeze_mode <= 1'b1;
      pulse();
      repeat (40) @(posedge pclk);
      chk("freeze", sampling, f == 3);
      repeat (110) @(posedge pclk);
      chk("freeze_end", sampling, f >= 2);
      freeze_mode <= 1'b0;
    end
    $display("test power and freeze done");
    final_report();
  end
endmodule

// File: logic/asc_ctrl.sv
/*
  Configuration and control of an 8-channel, 10-bit successive-approximation
  converter sequencer: registers over APB, conversion clock prescaler,
  sample phases, sequence length, result placement, flags and triggering.
  Assumes the analog core presents a settled code on conv_code at the end of
  each conversion, and that the start pulse, scan and trigger inputs are
  synchronous to pclk.
*/
`timescale 1ns/10ps
// ============================================================================
module asc_ctrl (
  input  wire logic        pclk,         // bus clock
  input  wire logic        presetn,      // async reset, active low
  input  wire logic        pclk_en,      // freezes all state while low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error on unmapped address
  input  wire logic        seq_start,    // pulse: start a new sequence
  input  wire logic        scan_mode,    // continuous sequences
  input  wire logic        wait_mode,    // cpu in wait mode
  input  wire logic        freeze_mode,  // debug breakpoint active
  input  wire logic        trig_in,      // selected external trigger level
  input  wire logic        trig_is_chan, // trigger source is an analog channel
  input  wire logic [9:0]  conv_code,    // settled code from analog core
  output logic             irq,          // sequence complete interrupt
  output logic             conv_clk,     // divided conversion clock
  output logic             powered,      // analog core powered
  output logic             trig_buf_en,  // digital buffer on trigger channel
  output logic             sampling,     // sample phase active
  output logic [2:0]       conv_count,   // next result slot
  output logic             ignore_next   // result unreliable after wake
);

  asc_pkg::asc_state_t r;
  asc_pkg::asc_state_t next_r;

  // ==========================================================================
  // outputs straight from the state register
  assign prdata      = r.prdata;
  assign pready      = r.pready;
  assign pslverr     = r.pslverr;
  assign irq         = r.irq;
  assign conv_clk    = r.conv_clk;
  assign powered     = r.powered;
  assign trig_buf_en = r.trig_buf_en;
  assign sampling    = r.sampling;
  assign conv_count  = r.conv_count;
  assign ignore_next = r.ignore_next;

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic        acc;
    logic        wr;
    logic        rd;
    logic        is_res;
    logic [2:0]  res_n;
    logic        hit;
    logic [31:0] rdat;
    logic        tick;
    logic        halted;
    logic        frz_now;
    logic        frz_end;
    logic [3:0]  seq_len;
    logic [4:0]  smp_len;
    logic [4:0]  conv_len;
    logic        trig_hit;
    logic        trig_lvl;
    logic        start;
    logic        abort;
    logic        conv_done;
    logic        seq_done;
    logic [7:0]  ccf_set;
    logic [7:0]  ccf_clr;
    acc      = 1'b0;
    wr       = 1'b0;
    rd       = 1'b0;
    is_res   = 1'b0;
    res_n    = 3'h0;
    hit      = 1'b0;
    rdat     = 32'h0000_0000;
    tick     = 1'b0;
    halted   = 1'b0;
    frz_now  = 1'b0;
    frz_end  = 1'b0;
    seq_len  = 4'h0;
    smp_len  = 5'h00;
    conv_len = 5'h00;
    trig_hit = 1'b0;
    trig_lvl = 1'b0;
    start    = 1'b0;
    abort    = 1'b0;
    conv_done = 1'b0;
    seq_done = 1'b0;
    ccf_set  = 8'h00;
    ccf_clr  = 8'h00;
    next_r   = r;

    // bus handshake: one wait state, request completes when pready is seen
    acc    = psel && penable && r.pready;
    wr     = acc && pwrite;
    rd     = acc && !pwrite;
    is_res = (paddr[7:6] == asc_pkg::ADDR_RESULT0[7:6]) && (paddr[2:0] == 3'h0);
    res_n  = paddr[5:3];

    // read mux, prepared while pready rises
    hit = 1'b1;
    if (is_res) begin
      rdat = {22'h000000, r.result[res_n]};
    end else begin
      case (paddr)
        {asc_pkg::IDX_TRIG_IRQ[5:0], 2'b00}: begin
          rdat = {25'h0000000, r.cfg.fast_flag_clear, r.cfg.wait_power_down, r.cfg.tle, r.cfg.tp,
                  r.cfg.te, r.cfg.ie, r.cfg.ie & r.sequence_complete_flag};
        end
        {asc_pkg::IDX_SEQ_FIFO[5:0], 2'b00}: begin
          rdat = {25'h0000000, r.cfg.len, r.cfg.fifo, r.cfg.frz};
        end
        {asc_pkg::IDX_TIMING[5:0], 2'b00}: begin
          rdat = {24'h000000, r.cfg.res8, r.cfg.smp, r.cfg.conv_clock_prescaler};
        end
        {asc_pkg::IDX_SEQ_STAT[5:0], 2'b00}: begin
          rdat = {24'h000000, r.sequence_complete_flag, 1'b0, r.trigger_overrun_flag, r.fifor, 1'b0, r.conv_count};
        end
        {asc_pkg::IDX_CCF_STAT[5:0], 2'b00}: begin
          rdat = {24'h000000, r.ccf};
        end
        default: begin
          hit  = 1'b0;
          rdat = 32'h0000_0000;
        end
      endcase
    end
    next_r.pready  = psel && penable && !r.pready;
    next_r.pslverr = 1'b0;  // error stands only beside ready
    if (psel && penable && !r.pready) begin
      next_r.prdata  = pwrite ? 32'h0000_0000 : rdat;
      next_r.pslverr = !hit;
    end

    // register writes; pending flag bit 0 is not writable
    abort = 1'b0;
    if (wr && !is_res) begin
      case (paddr)
        {asc_pkg::IDX_TRIG_IRQ[5:0], 2'b00}: begin
          next_r.cfg.fast_flag_clear = pwdata[asc_pkg::TI_FAST_FLAG_CLEAR];
          next_r.cfg.wait_power_down = pwdata[asc_pkg::TI_WAIT_POWER_DOWN];
          next_r.cfg.tle  = pwdata[asc_pkg::TI_TLE];
          next_r.cfg.tp   = pwdata[asc_pkg::TI_TP];
          next_r.cfg.te   = pwdata[asc_pkg::TI_TE];
          next_r.cfg.ie   = pwdata[asc_pkg::TI_IE];
          abort = 1'b1;
        end
        {asc_pkg::IDX_SEQ_FIFO[5:0], 2'b00}: begin
          next_r.cfg.len  = pwdata[asc_pkg::SF_LEN +: 4];
          next_r.cfg.fifo = pwdata[asc_pkg::SF_FIFO];
          next_r.cfg.frz  = pwdata[asc_pkg::SF_FRZ +: 2];
          abort = 1'b1;
        end
        {asc_pkg::IDX_TIMING[5:0], 2'b00}: begin
          next_r.cfg.res8 = pwdata[asc_pkg::TM_RES8];
          next_r.cfg.smp  = pwdata[asc_pkg::TM_SMP +: 2];
          next_r.cfg.conv_clock_prescaler  = pwdata[asc_pkg::TM_PRS +: 5];
          abort = 1'b1;
        end
        {asc_pkg::IDX_SEQ_STAT[5:0], 2'b00}: begin
          if (pwdata[asc_pkg::SS_SCF]) next_r.sequence_complete_flag = 1'b0;
          if (pwdata[asc_pkg::SS_TRIGGER_OVERRUN_FLAG]) next_r.trigger_overrun_flag = 1'b0;
          if (pwdata[asc_pkg::SS_FIFOR]) next_r.fifor = 1'b0;
        end
        default: begin
          abort = 1'b0;
        end
      endcase
    end

    // status read arms every raised flag for the normal clearing sequence
    if (rd && (paddr == {asc_pkg::IDX_CCF_STAT[5:0], 2'b00})) begin
      next_r.armed = r.armed | r.ccf;
    end
    if (acc && is_res) begin
      if (r.cfg.fast_flag_clear) begin
        ccf_clr[res_n] = 1'b1;
      end else if (rd && r.armed[res_n]) begin
        ccf_clr[res_n] = 1'b1;
      end
    end

    // conversion clock: toggle every prs+1 bus clocks, tick on rising half
    halted = r.cfg.wait_power_down && wait_mode;
    if (r.div == r.cfg.conv_clock_prescaler) begin
      next_r.div      = 5'h00;
      next_r.conv_clk = !r.conv_clk;
      tick            = !r.conv_clk;
    end else begin
      next_r.div = r.div + 5'h01;
    end
    next_r.powered   = !halted;
    next_r.wait_prev = halted;
    if (r.wait_prev && !halted && r.seq != asc_pkg::SQ_IDLE) begin
      next_r.ignore_next = 1'b1;
    end

    // freeze response; reserved code continues like code zero
    frz_now = freeze_mode && (r.cfg.frz == asc_pkg::FRZ_NOW);
    frz_end = freeze_mode && (r.cfg.frz == asc_pkg::FRZ_FINISH);

    // decoded lengths
    seq_len = (r.cfg.len[3] || r.cfg.len == 4'h0) ? 4'h8 : {1'b0, r.cfg.len[2:0]};
    smp_len = 5'h02 << r.cfg.smp;
    conv_len = r.cfg.res8 ? asc_pkg::CONV8_CYC : asc_pkg::CONV10_CYC;

    // external trigger detection
    next_r.trig_prev   = trig_in;
    next_r.trig_buf_en = r.cfg.te && trig_is_chan;
    case ({r.cfg.tle, r.cfg.tp})
      2'b00: trig_hit = r.trig_prev && !trig_in;
      2'b01: trig_hit = !r.trig_prev && trig_in;
      2'b10: trig_lvl = !trig_in;
      2'b11: trig_lvl = trig_in;
      default: trig_hit = 1'b0;
    endcase
    trig_hit = r.cfg.te && (trig_hit || trig_lvl);
    if (trig_hit && !r.cfg.tle && r.seq != asc_pkg::SQ_IDLE) begin
      next_r.trigger_overrun_flag = 1'b1;
    end

    // sequence start from software or trigger
    start = seq_start || (trig_hit && r.seq == asc_pkg::SQ_IDLE && !abort);
    if (start) begin
      if (seq_start) begin
        next_r.sequence_complete_flag   = 1'b0;
        next_r.trigger_overrun_flag = 1'b0;
      end
      next_r.fifor    = 1'b0;
      next_r.seq      = asc_pkg::SQ_SAMP1;
      next_r.phase    = 5'h00;
      next_r.done_cnt = 4'h0;
      if (!r.cfg.fifo) next_r.conv_count = 3'h0;
    end else if (abort) begin
      next_r.seq   = asc_pkg::SQ_IDLE;
      next_r.trigger_overrun_flag = 1'b0;
    end else if (tick && !halted && !frz_now) begin
      case (r.seq)
        asc_pkg::SQ_SAMP1: begin
          if (frz_end && r.phase == 5'h00 && r.done_cnt != 4'h0) begin
            next_r.phase = 5'h00;  // parked between conversions
          end else if (r.phase == asc_pkg::SAMPLE1_CYC - 5'h01) begin
            next_r.phase = 5'h00;
            next_r.seq   = asc_pkg::SQ_SAMP2;
          end else begin
            next_r.phase = r.phase + 5'h01;
          end
        end
        asc_pkg::SQ_SAMP2: begin
          if (r.phase == smp_len - 5'h01) begin
            next_r.phase = 5'h00;
            next_r.seq   = asc_pkg::SQ_CONV;
          end else begin
            next_r.phase = r.phase + 5'h01;
          end
        end
        asc_pkg::SQ_CONV: begin
          if (r.phase == conv_len - 5'h01) begin
            conv_done    = 1'b1;
            next_r.phase = 5'h00;
            seq_done     = (r.done_cnt + 4'h1) == seq_len;
            next_r.done_cnt = r.done_cnt + 4'h1;
            next_r.seq   = asc_pkg::SQ_SAMP1;
            if (seq_done) begin
              next_r.done_cnt = 4'h0;
              next_r.seq = scan_mode ? asc_pkg::SQ_SAMP1 : asc_pkg::SQ_IDLE;
              if (!r.cfg.fifo) next_r.conv_count = 3'h0;
              else next_r.conv_count = r.conv_count + 3'h1;
            end else begin
              next_r.conv_count = r.conv_count + 3'h1;
            end
          end else begin
            next_r.phase = r.phase + 5'h01;
          end
        end
        default: begin
          next_r.phase = 5'h00;
        end
      endcase
    end
    if (conv_done) begin
      next_r.result[r.conv_count] = r.cfg.res8 ? {2'b00, conv_code[9:2]} : conv_code;
      ccf_set[r.conv_count] = 1'b1;
      if (r.ccf[r.conv_count]) next_r.fifor = 1'b1;
      next_r.ignore_next = 1'b0;
    end
    if (seq_done) begin
      next_r.sequence_complete_flag = 1'b1;
    end

    // a flag set in the same cycle as its clear stays set
    next_r.ccf   = (r.ccf & ~ccf_clr) | ccf_set;
    next_r.armed = next_r.armed & ~ccf_clr & ~ccf_set;
    next_r.sampling = (next_r.seq == asc_pkg::SQ_SAMP1) || (next_r.seq == asc_pkg::SQ_SAMP2);
    next_r.irq = next_r.cfg.ie && next_r.sequence_complete_flag;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.cfg.len  <= asc_pkg::RST_SEQ_LEN;
      r.cfg.conv_clock_prescaler  <= asc_pkg::RST_PRS;
      r.seq      <= asc_pkg::SQ_IDLE;
      r.powered  <= 1'b1;
    end else if (pclk_en) begin
      r <= next_r;
    end
  end

endmodule

// File: logic/asc_pkg.sv
/*
  Shared constants and types for the converter sequencer control block:
  register indices, field layouts, reset values and sequencer timing counts.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package asc_pkg;
  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_TRIG_IRQ  = 8'h02;  // trigger_irq_control
  localparam logic [7:0] IDX_SEQ_FIFO  = 8'h03;  // sequence_fifo_freeze_control
  localparam logic [7:0] IDX_TIMING    = 8'h04;  // timing_resolution_control
  localparam logic [7:0] IDX_SEQ_STAT  = 8'h06;  // sequence_status
  localparam logic [7:0] IDX_CCF_STAT  = 8'h0B;  // complete_flags_status
  localparam logic [7:0] IDX_RESULT0   = 8'h10;  // result n at index 10h + 2n
  localparam logic [7:0] ADDR_RESULT0  = 8'h40;  // byte address of result 0
  localparam int         N_RESULTS     = 8;

  // ==========================================================================
  // field positions
  localparam int TI_FAST_FLAG_CLEAR = 6;  // fast_flag_clear
  localparam int TI_WAIT_POWER_DOWN = 5;  // wait_power_down
  localparam int TI_TLE  = 4;  // trigger_level_edge_select
  localparam int TI_TP   = 3;  // trigger_polarity
  localparam int TI_TE   = 2;  // trigger_enable
  localparam int TI_IE   = 1;  // seq_done_irq_enable
  localparam int TI_IF   = 0;  // seq_done_irq_flag (read only)
  localparam int SF_LEN  = 3;  // seq_length_bit3..0 at [6:3]
  localparam int SF_FIFO = 2;
  localparam int SF_FRZ  = 0;  // freeze_behavior_hi/lo at [1:0]
  localparam int TM_RES8 = 7;  // low_resolution_select
  localparam int TM_SMP  = 5;  // sample_phase_hi/lo at [6:5]
  localparam int TM_PRS  = 0;  // conv_clock_prescaler at [4:0]
  localparam int SS_SCF  = 7;
  localparam int SS_TRIGGER_OVERRUN_FLAG = 5;
  localparam int SS_FIFOR = 4;

  // ==========================================================================
  // reset values
  localparam logic [3:0] RST_SEQ_LEN = 4'h4;
  localparam logic [4:0] RST_PRS     = 5'h05;

  // ==========================================================================
  // sequencer timing, in conversion clock cycles
  localparam logic [4:0] SAMPLE1_CYC = 5'h02;
  localparam logic [4:0] CONV10_CYC  = 5'h0A;
  localparam logic [4:0] CONV8_CYC   = 5'h08;

  // ==========================================================================
  // freeze codes
  localparam logic [1:0] FRZ_FINISH = 2'h2;
  localparam logic [1:0] FRZ_NOW    = 2'h3;

  typedef enum logic [1:0] {SQ_IDLE, SQ_SAMP1, SQ_SAMP2, SQ_CONV} asc_seq_t;

  typedef struct packed {
    logic       fast_flag_clear;
    logic       wait_power_down;
    logic       tle;
    logic       tp;
    logic       te;
    logic       ie;
    logic [3:0] len;
    logic       fifo;
    logic [1:0] frz;
    logic       res8;
    logic [1:0] smp;
    logic [4:0] conv_clock_prescaler;
  } asc_cfg_t;

  typedef struct packed {
    asc_cfg_t            cfg;
    logic                sequence_complete_flag;
    logic                trigger_overrun_flag;
    logic                fifor;
    logic [7:0]          ccf;
    logic [7:0]          armed;
    logic [7:0][9:0]     result;
    asc_seq_t            seq;
    logic [4:0]          phase;
    logic [2:0]          conv_count;
    logic [3:0]          done_cnt;
    logic [4:0]          div;
    logic                conv_clk;
    logic                trig_prev;
    logic                wait_prev;
    logic                ignore_next;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                irq;
    logic                powered;
    logic                trig_buf_en;
    logic                sampling;
  } asc_state_t;
endpackage
